/* sledc_consts.svh */
// constants and offsets for the status indicator controller
// What this block does
// (R1) blink power green seven seconds during test
// (R2) pass: power steady green, module ready lit
// (R3) fail: power red, device inactive
// (R4) failed device never transmits on network
// (R5) test leaves network and field outputs untouched
// (R6) checksum copy failure lights status red
// (R7) no failure keeps status dark
// (R8) unsaved configuration: status steadily lit
// (R9) lost parameters: one green status flash
// (R10) base fault or illegal module: two flashes
// (R11) PID initializing: process flashes green
// (R12) all PID in target: process green
// (R13) alarm priority above eight: process red
// (R14) port not receiving: network off
// (R15) link scheduler role: network flashes green
// (R16) basic device: network steady green
// (R17) default address with traffic: red/green alternate
// (R18) fatal network error: network steady red
// (R19) restart value written: restart processor
// (R20) autoconfigure while out of service: query modules
// (R21) firmware update done: clear stored configuration
// (R22) alarm red wins; codes repeat with pause
`ifndef SLEDC_CONSTS_SVH
`define SLEDC_CONSTS_SVH
`define SLEDC_CLK_HZ        40000000
`define SLEDC_POST_MS       7000
`define SLEDC_POST_CYC      ((`SLEDC_CLK_HZ / 1000) * `SLEDC_POST_MS)
`define SLEDC_FLASH_MS      250
`define SLEDC_FLASH_CYC     ((`SLEDC_CLK_HZ / 1000) * `SLEDC_FLASH_MS)
`define SLEDC_PAUSE_PH      4'h6
`define SLEDC_ALARM_LIMIT   4'h8
`define SLEDC_MAX_BASES     4'h9
`define SLEDC_ADDR_CTRL     4'h0
`define SLEDC_ADDR_STAT     4'h4
`define SLEDC_ADDR_PROC     4'h8
`define SLEDC_ADDR_NET      4'hc
`define SLEDC_CTRL_RESTART  0
`define SLEDC_CTRL_AUTOCFG  1
`define SLEDC_CTRL_OOS      2
`define SLEDC_CTRL_FWDONE   3
`define SLEDC_CTRL_UNSAVED  4
`define SLEDC_CTRL_LOST     5
`endif

/* sledc_pkg.sv */
// types for the status indicator controller
package sledc_pkg;
    // two-bit led colour code
    typedef enum logic [1:0] {
        SLEDC_OFF   = 2'h0,
        SLEDC_GREEN = 2'h1,
        SLEDC_RED   = 2'h2
    } sledc_color_t;

    typedef enum logic [2:0] {
        SLEDC_S_TEST = 3'h1,
        SLEDC_S_PASS = 3'h2,
        SLEDC_S_FAIL = 3'h4
    } sledc_state_t;

    // network port condition from the link layer
    typedef struct packed {
        logic receiving;
        logic scheduler;
        logic default_addr;
        logic fatal;
    } sledc_net_t;

    // process control condition
    typedef struct packed {
        logic       pid_init;
        logic       pid_all_target;
        logic [3:0] alarm_prio;
    } sledc_proc_t;

    typedef struct packed {
        logic [1:0] power;
        logic [1:0] status;
        logic [1:0] process;
        logic [1:0] network;
        logic       ready;
    } sledc_leds_t;

    // all state of the controller
    typedef struct packed {
        sledc_state_t state;
        logic [28:0]  post_cnt;
        logic [23:0]  tick_cnt;
        logic [3:0]   phase;
        logic [5:0]   ctrl;
        logic         restart;
        logic         autocfg;
        logic         cfg_clear;
        logic [31:0]  rdata;
        sledc_leds_t  leds;
    } sledc_regs_t;
endpackage

/* sledc_top.sv */
// indicator and health logic for the fieldbus network module
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "sledc_consts.svh"
module sledc_top (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [3:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [31:0]            rdata_o,
    input  wire logic              post_fail_i,
    input  wire logic              csum_err_i,
    input  wire logic [3:0]        base_count_i,
    input  wire logic              base_hotadd_i,
    input  wire logic              module_illegal_i,
    input  wire sledc_pkg::sledc_proc_t proc_i,
    input  wire sledc_pkg::sledc_net_t  net_i,
    input  wire logic              net_tx_req_i,
    input  wire logic              field_wr_req_i,
    output logic                   net_tx_en_o,
    output logic                   field_wr_en_o,
    output sledc_pkg::sledc_leds_t leds_o,
    output logic                   restart_o,
    output logic                   autocfg_o,
    output logic                   cfg_clear_o
);
    import sledc_pkg::*;

    localparam logic [28:0] POST_CYC  = 29'(`SLEDC_POST_CYC);
    localparam logic [23:0] FLASH_CYC = 24'(`SLEDC_FLASH_CYC);

    sledc_regs_t q;
    sledc_regs_t d;
    logic        tick;
    logic        base_fault;
    logic [1:0]  flashes;

    // flash-count pattern: n on-phases then a pause of dark phases
    function automatic logic code_on(input logic [3:0] ph, input logic [1:0] n);
        code_on = (ph[0] == 1'b0) && (ph[3:1] < {1'b0, n});
    endfunction

    assign tick = (q.tick_cnt == FLASH_CYC - 24'h1);
    assign base_fault = (base_count_i > `SLEDC_MAX_BASES) | base_hotadd_i | module_illegal_i;
    assign flashes = base_fault ? 2'h2 : 2'h1;

    always_comb
    begin
        d = q;
        d.restart   = 1'b0;
        d.autocfg   = 1'b0;
        d.cfg_clear = 1'b0;
        // flash time base, free running
        d.tick_cnt = tick ? 24'h0 : q.tick_cnt + 24'h1;
        if (tick)
        begin
            // (R22) repeat with pause
            d.phase = (q.phase == 4'h3 + `SLEDC_PAUSE_PH) ? 4'h0 : q.phase + 4'h1;
        end
        case (q.state)
            SLEDC_S_TEST:
            begin
                // (R1) blink during test
                // lit on even phases so the blink starts lit right after reset
                d.leds.power = q.phase[0] ? SLEDC_OFF : SLEDC_GREEN;
                d.post_cnt = q.post_cnt + 29'h1;
                if (q.post_cnt == POST_CYC - 29'h1)
                begin
                    // (R3) failed test goes inactive
                    d.state = post_fail_i ? SLEDC_S_FAIL : SLEDC_S_PASS;
                end
            end
            SLEDC_S_PASS:
            begin
                // (R2) steady green, ready
                d.leds.power = SLEDC_GREEN;
            end
            SLEDC_S_FAIL:
            begin
                // (R3) power red
                d.leds.power = SLEDC_RED;
            end
            default:
            begin
                d.state = SLEDC_S_TEST;
            end
        endcase
        d.leds.ready = (q.state == SLEDC_S_PASS);
        // status: red checksum, then codes, then unsaved, else dark
        if (csum_err_i)
        begin
            // (R6) checksum red
            d.leds.status = SLEDC_RED;
        end
        else if (base_fault || q.ctrl[`SLEDC_CTRL_LOST])
        begin
            // (R9) one green flash
            // (R10) two flashes on base faults
            d.leds.status = code_on(q.phase, flashes) ? SLEDC_GREEN : SLEDC_OFF;
        end
        else if (q.ctrl[`SLEDC_CTRL_UNSAVED])
        begin
            // (R8) steady lit
            d.leds.status = SLEDC_GREEN;
        end
        else
        begin
            // (R7) dark without failure
            d.leds.status = SLEDC_OFF;
        end
        // (R13) alarm red wins
        if (proc_i.alarm_prio > `SLEDC_ALARM_LIMIT)
            d.leds.process = SLEDC_RED;
        // (R11) init flashes
        else if (proc_i.pid_init)
            d.leds.process = q.phase[0] ? SLEDC_OFF : SLEDC_GREEN;
        // (R12) all in target
        else if (proc_i.pid_all_target)
            d.leds.process = SLEDC_GREEN;
        else
            d.leds.process = SLEDC_OFF;
        // network led, fatal error first
        if (net_i.fatal)
            // (R18) steady red
            d.leds.network = SLEDC_RED;
        else if (!net_i.receiving)
            // (R14) off when silent
            d.leds.network = SLEDC_OFF;
        else if (net_i.default_addr)
            // (R17) red green alternate
            d.leds.network = q.phase[0] ? SLEDC_RED : SLEDC_GREEN;
        else if (net_i.scheduler)
            // (R15) scheduler flashes
            d.leds.network = q.phase[0] ? SLEDC_OFF : SLEDC_GREEN;
        else
            // (R16) basic device steady
            d.leds.network = SLEDC_GREEN;
        // register writes; command bits self-clear
        if (wr_i && addr_i == `SLEDC_ADDR_CTRL)
        begin
            d.ctrl = wdata_i[5:0];
            // (R19) restart pulse
            d.restart = wdata_i[`SLEDC_CTRL_RESTART];
            // (R20) autoconfig only out of service
            d.autocfg = wdata_i[`SLEDC_CTRL_AUTOCFG] & wdata_i[`SLEDC_CTRL_OOS];
            // (R21) clear on firmware done
            d.cfg_clear = wdata_i[`SLEDC_CTRL_FWDONE];
            if (wdata_i[`SLEDC_CTRL_FWDONE])
                d.ctrl[`SLEDC_CTRL_UNSAVED] = 1'b0;
            d.ctrl[`SLEDC_CTRL_RESTART] = 1'b0;
            d.ctrl[`SLEDC_CTRL_AUTOCFG] = 1'b0;
            d.ctrl[`SLEDC_CTRL_FWDONE]  = 1'b0;
        end
        // read data, one cycle later, zero otherwise
        d.rdata = 32'h0;
        if (rd_i)
        begin
            case (addr_i)
                `SLEDC_ADDR_CTRL: d.rdata = {26'h0, q.ctrl};
                `SLEDC_ADDR_STAT: d.rdata = {29'h0, q.state};
                `SLEDC_ADDR_PROC: d.rdata = {30'h0, q.leds.process};
                `SLEDC_ADDR_NET:  d.rdata = {24'h0, q.leds.network, q.leds.status,
                                             q.leds.power, 1'b0, q.leds.ready};
                default:          d.rdata = 32'h0;
            endcase
        end
    end

    // single state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q       <= '0;
            q.state <= SLEDC_S_TEST;
        end
        else
        begin
            q <= d;
        end
    end

    // (R4) no transmit unless passed
    // (R5) test holds network and field quiet
    assign net_tx_en_o   = net_tx_req_i & (q.state == SLEDC_S_PASS);
    assign field_wr_en_o = field_wr_req_i & (q.state == SLEDC_S_PASS);
    assign leds_o        = q.leds;
    assign rdata_o       = q.rdata;
    assign restart_o     = q.restart;
    assign autocfg_o     = q.autocfg;
    assign cfg_clear_o   = q.cfg_clear;

    // (R4) failed state blocks transmit
    chk_fail_no_tx: assert property (@(posedge clk_i) disable iff (rst_i) // (R4)
        q.state == SLEDC_S_FAIL |-> !net_tx_en_o)
        else $error("transmit after failed test");
    // (R5) quiet during test
    chk_test_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // (R5)
        q.state == SLEDC_S_TEST |-> !net_tx_en_o && !field_wr_en_o)
        else $error("output during self test");
    // (R3) fail shows red
    chk_fail_red: assert property (@(posedge clk_i) disable iff (rst_i) // (R3)
        $past(q.state) == SLEDC_S_FAIL && q.state == SLEDC_S_FAIL |-> leds_o.power == SLEDC_RED)
        else $error("failed test not red");
    // (R2) pass shows green and ready
    chk_pass_green: assert property (@(posedge clk_i) disable iff (rst_i) // (R2)
        $past(q.state) == SLEDC_S_PASS && q.state == SLEDC_S_PASS
        |-> leds_o.power == SLEDC_GREEN && leds_o.ready)
        else $error("passed test not green");
    // (R13) alarm red
    chk_alarm_red: assert property (@(posedge clk_i) disable iff (rst_i) // (R13)
        proc_i.alarm_prio > 4'h8 |=> leds_o.process == SLEDC_RED)
        else $error("alarm not red");
    // (R18) fatal red
    chk_fatal_red: assert property (@(posedge clk_i) disable iff (rst_i) // (R18)
        net_i.fatal |=> leds_o.network == SLEDC_RED)
        else $error("fatal not red");
    // (R14) silent port off
    chk_silent_off: assert property (@(posedge clk_i) disable iff (rst_i) // (R14)
        !net_i.fatal && !net_i.receiving |=> leds_o.network == SLEDC_OFF)
        else $error("silent port lit");
    // (R6) checksum red
    chk_csum_red: assert property (@(posedge clk_i) disable iff (rst_i) // (R6)
        csum_err_i |=> leds_o.status == SLEDC_RED)
        else $error("checksum not red");
    // (R20) autoconfig needs out of service
    chk_autocfg_oos: assert property (@(posedge clk_i) disable iff (rst_i) // (R20)
        wr_i && addr_i == 4'h0 && !wdata_i[2] |=> !autocfg_o)
        else $error("autoconfig while in service");
    // (R19) restart pulse follows write
    chk_restart: assert property (@(posedge clk_i) disable iff (rst_i) // (R19)
        wr_i && addr_i == 4'h0 && wdata_i[0] |=> restart_o)
        else $error("restart pulse wrong");
    // (R19) pulse only after a restart write; back to back writes allowed
    chk_restart_src: assert property (@(posedge clk_i) disable iff (rst_i) // (R19)
        restart_o |-> $past(wr_i && addr_i == 4'h0 && wdata_i[0]))
        else $error("restart pulse without write");
endmodule

/* sledc_net_model.sv */
// fieldbus link model driving the port condition seen by the controller
`timescale 1ns/1ps
module sledc_net_model
    import sledc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [2:0] mode_i,
    output sledc_net_t      net_o
);
    // ****************************************
    // link condition per mode
    // ****************************************
    // 0 silent, 1 basic, 2 scheduler, 3 default address, 4 fatal
    always_ff @(posedge clk_i)
    begin
        net_o.receiving    <= (mode_i != 3'h0);
        net_o.scheduler    <= (mode_i == 3'h2);
        net_o.default_addr <= (mode_i == 3'h3);
        net_o.fatal        <= (mode_i == 3'h4); // a dead link still shows traffic
    end
endmodule

/* tb_top.sv */
// self-checking bench for the status indicator controller
`timescale 1ns/1ps
module tb_top;
    import sledc_pkg::*;
    logic        clk, rst, wr, rd, csum, hot, ill, treq, freq, nte, fwe, rso, aco, cco;
    logic [3:0]  addr, bases;
    logic [31:0] wdata, rdata, got;
    logic [2:0]  mode;
    sledc_proc_t proc_s;
    sledc_net_t  net_s;
    sledc_leds_t leds;
    int          miscompares, n_checks;

    sledc_net_model NET (.clk_i(clk), .mode_i(mode), .net_o(net_s));
    sledc_top DUT (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .post_fail_i(1'b0), .csum_err_i(csum),
        .base_count_i(bases), .base_hotadd_i(hot), .module_illegal_i(ill), .proc_i(proc_s),
        .net_i(net_s), .net_tx_req_i(treq), .field_wr_req_i(freq), .net_tx_en_o(nte),
        .field_wr_en_o(fwe), .leds_o(leds), .restart_o(rso), .autocfg_o(aco),
        .cfg_clear_o(cco));

    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task check(string n, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask
    // pulses stand in the cycle after the write, sampled there
    task wr_reg(logic [3:0] a, logic [31:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask
    task rd_reg(logic [3:0] a);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 got = rdata;
    endtask
    // leds follow inputs one cycle late
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task summarize;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // tests need well under a thousand cycles; the self test never ends here
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize;
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        {rst, wr, rd, csum, hot, ill, treq, freq} = 8'h81;
        {addr, wdata, bases, mode} = '0;
        proc_s = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        treq <= 1'b1;
        freq <= 1'b1;
        settle;
        rd_reg(4'h4);
        check("state", got, 32'h1); // self test running
        check("power", 32'(leds.power), 32'(SLEDC_GREEN)); // blink starts lit
        check("ready", 32'(leds.ready), 32'h0); // not before pass
        check("tx", 32'(nte), 32'h0); // silent during test
        check("field", 32'(fwe), 32'h0); // field outputs untouched
        rd_reg(4'h2);
        check("unmapped", got, 32'h0);
        wr_reg(4'h3, 32'h3);
        check("unmapped wr", 32'({rso, aco}), 32'h0);
        check("status dark", 32'(leds.status), 32'(SLEDC_OFF)); // no fault seen
        csum <= 1'b1;
        bases <= 4'ha;
        settle;
        check("csum", 32'(leds.status), 32'(SLEDC_RED)); // red beats codes
        {csum, bases} <= 5'h09;
        wr_reg(4'h0, 32'h10);
        settle;
        check("unsaved", 32'(leds.status), 32'(SLEDC_GREEN)); // steadily lit
        repeat (60) @(posedge clk);
        #1 check("unsaved", 32'(leds.status), 32'(SLEDC_GREEN)); // still lit 60 cycles later, well inside one flash phase
        // each fault source alone gives the two-flash code, first flash lit
        for (int i = 0; i < 3; i++)
        begin
            bases <= (i == 0) ? 4'ha : 4'h9;
            hot <= (i == 1);
            ill <= (i == 2);
            settle;
            check("base code", 32'(leds.status), 32'(SLEDC_GREEN)); // two flashes
        end
        {bases, hot, ill} <= 6'h04;
        wr_reg(4'h0, 32'h18);
        check("cfg clear", 32'(cco), 32'h1); // firmware done
        settle;
        check("cleared", 32'(leds.status), 32'(SLEDC_OFF)); // unsaved dropped
        wr_reg(4'h0, 32'h20);
        settle;
        check("lost", 32'(leds.status), 32'(SLEDC_GREEN)); // single green flash
        wr_reg(4'h0, 32'h1);
        check("restart", 32'(rso), 32'h1); // restart pulse
        @(posedge clk);
        #1 check("restart", 32'(rso), 32'h0); // one cycle only
        wr_reg(4'h0, 32'h2);
        check("autocfg refused", 32'(aco), 32'h0); // needs out of service
        wr_reg(4'h0, 32'h6);
        check("autocfg", 32'(aco), 32'h1); // out of service given
        proc_s <= '{pid_init: 1'b0, pid_all_target: 1'b1, alarm_prio: 4'h8};
        settle;
        check("proc target", 32'(leds.process), 32'(SLEDC_GREEN)); // eight not red
        proc_s <= '{pid_init: 1'b1, pid_all_target: 1'b1, alarm_prio: 4'h9};
        settle;
        check("proc alarm", 32'(leds.process), 32'(SLEDC_RED)); // red wins
        rd_reg(4'h8);
        check("proc reg", got, 32'(SLEDC_RED));
        proc_s <= '{pid_init: 1'b1, pid_all_target: 1'b0, alarm_prio: 4'h0};
        settle;
        check("proc init", 32'(leds.process), 32'(SLEDC_GREEN)); // flashing, first lit
        // network condition table, walked in order of the model's modes
        for (int m = 0; m < 5; m++)
        begin
            mode <= 3'(m);
            settle;
            case (m)
                0: check("net", 32'(leds.network), 32'(SLEDC_OFF)); // silent port
                1: check("net", 32'(leds.network), 32'(SLEDC_GREEN)); // basic device
                2: check("net", 32'(leds.network), 32'(SLEDC_GREEN)); // scheduler lit
                3: check("net", 32'(leds.network != SLEDC_OFF), 32'h1); // alternating
                default: check("net", 32'(leds.network), 32'(SLEDC_RED)); // fatal
            endcase
        end
        summarize;
    end
endmodule
